//--- rtl/bit_branch_unit.sv
/*
  Branch, skip, bit-manipulation, shift/rotate and flag set/clear
  execution unit of the 8-bit core.
  Assumes decode presents one request at a time with the operand
  register, I/O location, flag register and PC values valid in the
  same cycle, and holds req_valid_i until it sees busy_o low.
*/
// How it works
// RULE_01: Skip past next word(s) when I/O bit one
// RULE_02: Generic flag branch tests selected flag bit
// RULE_03: Equal/not-equal branch on zero flag
// RULE_04: Carry and unsigned compare branches test carry
// RULE_05: Minus/plus branches test negative flag
// RULE_06: Signed compare branches test N xor V
// RULE_07: Half-carry branches test half-carry flag
// RULE_08: Transfer-bit branches, no flag changes
// RULE_09: Overflow branches test overflow flag
// RULE_10: Interrupt-state branches test global enable
// RULE_11: Force I/O bit one or zero, 2 cycles
// RULE_12: Logical shifts fill zero, update Z C N V
// RULE_13: Rotates pass through carry, update Z C N V
// RULE_14: Arithmetic shift keeps bit 7; nibble swap
// RULE_15: Force selected or dedicated flag bit
// RULE_16: Copy register bit into transfer flag
// RULE_17: Copy transfer flag into register bit
// RULE_18: Branch 1/2 cycles, skip 1/2/3 cycles
`timescale 1ns/100ps
`default_nettype none

module bit_branch_unit
  import bit_branch_pkg::*;
#(
  parameter int PC_W = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Request from decode
  input wire logic req_valid_i,
  input wire instr_req_s req_i,
  // Operand sources
  input wire logic [DATA_W-1:0] rd_data_i,
  input wire logic [DATA_W-1:0] io_data_i,
  input wire logic [DATA_W-1:0] flags_i,
  input wire logic [PC_W-1:0] pc_i,
  // Sequencing
  output logic busy_o,
  output logic done_o,
  // Program counter update
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_o,
  // Writebacks
  output logic rd_we_o,
  output logic [DATA_W-1:0] rd_wdata_o,
  output logic io_we_o,
  output logic [DATA_W-1:0] io_wdata_o,
  output logic flags_we_o,
  output logic [DATA_W-1:0] flags_o
);

  // ==========================================================
  // Elaboration check
  if (PC_W < OFFS_W + 1) begin : g_bad_pc_w
    $error("PC_W too narrow for the branch offset");
  end

  // ==========================================================
  // Request acceptance
  seq_e state_q, state_d;
  logic take;
  op_e op;
  logic [SEL_W-1:0] sel;

  assign take = req_valid_i && (state_q == ST_IDLE);
  assign op = req_i.op;
  assign sel = req_i.bit_sel;

  // ==========================================================
  // Branch condition
  logic is_branch;
  logic br_taken;

  branch_cond u_cond (
    .op_i(op),
    .bit_sel_i(sel),
    .flags_i(flags_i),
    .is_branch_o(is_branch),
    .taken_o(br_taken)
  );

  // ==========================================================
  // Skip test on the I/O bit
  logic is_skip;
  logic skip_taken;

  assign is_skip = (op == OP_SKIP_IF_IO_BIT_ONE);
  assign skip_taken = is_skip && io_data_i[sel]; // see RULE_01

  // ==========================================================
  // Target program counter values
  logic [PC_W-1:0] offs_ext;
  logic [PC_W-1:0] br_target;
  logic [PC_W-1:0] skip_step;
  logic [PC_W-1:0] skip_target;

  // Sign-extended offset k, target PC + k + 1
  assign offs_ext = {{(PC_W-OFFS_W){req_i.offset[OFFS_W-1]}}, req_i.offset};
  assign br_target = pc_i + offs_ext + PC_W'(1); // see RULE_02
  // Step over a one-word or two-word next instruction
  assign skip_step = req_i.next_two_word ? PC_W'(SKIP_TWO_WORD) : PC_W'(SKIP_ONE_WORD);
  assign skip_target = pc_i + skip_step; // see RULE_01

  // ==========================================================
  // Cycle count of the request
  logic [1:0] cycles;

  assign cycles = br_taken ? CYC_TWO : // see RULE_18
                  !skip_taken ? ((op == OP_IO_BIT_FORCE_ONE || op == OP_IO_BIT_FORCE_ZERO)
                                 ? CYC_TWO : CYC_ONE) : // see RULE_11
                  req_i.next_two_word ? CYC_THREE : CYC_TWO; // see RULE_18

  // ==========================================================
  // Per-bit insert into register (from the T flag) and I/O location
  logic [DATA_W-1:0] io_set;
  logic [DATA_W-1:0] io_clr;
  logic [DATA_W-1:0] rd_ins;

  for (genvar i = 0; i < DATA_W; i++) begin : g_bit
    assign io_set[i] = (sel == SEL_W'(i)) ? 1'b1 : io_data_i[i]; // see RULE_11
    assign io_clr[i] = (sel == SEL_W'(i)) ? 1'b0 : io_data_i[i]; // see RULE_11
    assign rd_ins[i] = (sel == SEL_W'(i)) ? flags_i[FLAG_T] : rd_data_i[i]; // see RULE_17
  end

  // ==========================================================
  // Shift and rotate datapath
  logic is_shift;
  logic [DATA_W-1:0] sh_res;
  logic sh_c;
  logic [DATA_W-1:0] sh_flags;

  assign is_shift = (op == OP_LOGICAL_SHIFT_UP) || (op == OP_LOGICAL_SHIFT_DOWN) ||
                    (op == OP_ROTATE_UP_VIA_CARRY) || (op == OP_ROTATE_DOWN_VIA_CARRY) ||
                    (op == OP_ARITH_SHIFT_DOWN);

  // Result byte per shift kind
  assign sh_res =
    (op == OP_LOGICAL_SHIFT_UP) ? {rd_data_i[6:0], 1'b0} : // see RULE_12
    (op == OP_LOGICAL_SHIFT_DOWN) ? {1'b0, rd_data_i[7:1]} : // see RULE_12
    (op == OP_ROTATE_UP_VIA_CARRY) ? {rd_data_i[6:0], flags_i[FLAG_C]} : // see RULE_13
    (op == OP_ROTATE_DOWN_VIA_CARRY) ? {flags_i[FLAG_C], rd_data_i[7:1]} : // see RULE_13
    {rd_data_i[7], rd_data_i[7:1]}; // see RULE_14

  // Bit shifted out becomes carry
  assign sh_c = (op == OP_LOGICAL_SHIFT_UP || op == OP_ROTATE_UP_VIA_CARRY)
                ? rd_data_i[7] : rd_data_i[0]; // see RULE_13

  // Z, C, N, V updated; V is N xor C after the shift
  always_comb begin
    sh_flags = flags_i;
    sh_flags[FLAG_Z] = (sh_res == DATA_RST); // see RULE_12
    sh_flags[FLAG_C] = sh_c;
    sh_flags[FLAG_N] = sh_res[7];
    sh_flags[FLAG_V] = sh_res[7] ^ sh_c;
  end

  // ==========================================================
  // Flag force: selected bit or a dedicated flag
  logic is_fset;
  logic is_fclr;
  logic [SEL_W-1:0] fidx;
  logic [DATA_W-1:0] fmask;
  logic [DATA_W-1:0] force_flags;
  logic [DATA_W-1:0] tstore_flags;

  assign is_fset = (op == OP_FLAG_BIT_FORCE_ONE) || (op == OP_CARRY_ONE) ||
                   (op == OP_NEGATIVE_ONE) || (op == OP_ZERO_ONE) ||
                   (op == OP_GLOBAL_IRQ_ENABLE);
  assign is_fclr = (op == OP_FLAG_BIT_FORCE_ZERO) || (op == OP_CARRY_ZERO) ||
                   (op == OP_NEGATIVE_ZERO) || (op == OP_ZERO_ZERO) ||
                   (op == OP_GLOBAL_IRQ_DISABLE);
  assign fidx =
    (op == OP_CARRY_ONE || op == OP_CARRY_ZERO) ? SEL_W'(FLAG_C) : // see RULE_15
    (op == OP_NEGATIVE_ONE || op == OP_NEGATIVE_ZERO) ? SEL_W'(FLAG_N) :
    (op == OP_ZERO_ONE || op == OP_ZERO_ZERO) ? SEL_W'(FLAG_Z) :
    (op == OP_GLOBAL_IRQ_ENABLE || op == OP_GLOBAL_IRQ_DISABLE) ? SEL_W'(FLAG_I) :
    sel;
  assign fmask = DATA_W'(1) << fidx;
  assign force_flags = is_fset ? (flags_i | fmask) : (flags_i & ~fmask); // see RULE_15

  // Transfer bit takes the selected register bit
  always_comb begin
    tstore_flags = flags_i;
    tstore_flags[FLAG_T] = rd_data_i[sel]; // see RULE_16
  end

  // ==========================================================
  // Writeback set of the request
  wb_s wb;

  always_comb begin
    wb = '0;
    if (is_shift) begin
      wb.rd_we = 1'b1; // see RULE_12
      wb.rd_wdata = sh_res;
      wb.flags_we = 1'b1;
      wb.flags = sh_flags;
    end else if (op == OP_NIBBLE_EXCHANGE) begin
      wb.rd_we = 1'b1; // see RULE_14
      wb.rd_wdata = {rd_data_i[3:0], rd_data_i[7:4]};
    end else if (op == OP_IO_BIT_FORCE_ONE || op == OP_IO_BIT_FORCE_ZERO) begin
      wb.io_we = 1'b1; // see RULE_11
      wb.io_wdata = (op == OP_IO_BIT_FORCE_ONE) ? io_set : io_clr;
    end else if (is_fset || is_fclr) begin
      wb.flags_we = 1'b1; // see RULE_15
      wb.flags = force_flags;
    end else if (op == OP_STORE_BIT_TO_TRANSFER) begin
      wb.flags_we = 1'b1; // see RULE_16
      wb.flags = tstore_flags;
    end else if (op == OP_LOAD_BIT_FROM_TRANSFER) begin
      wb.rd_we = 1'b1; // see RULE_17
      wb.rd_wdata = rd_ins;
    end
  end

  // ==========================================================
  // Held results of a multi-cycle request
  wb_s hold_q;
  logic hold_pc_load_q;
  logic [PC_W-1:0] hold_pc_q;
  logic [1:0] left_q;
  logic pc_load_now;
  logic [PC_W-1:0] pc_now;
  logic fire;
  logic multi;

  // Branches and skips touch no flag: only the PC changes
  assign pc_load_now = br_taken || skip_taken; // see RULE_08
  assign pc_now = skip_taken ? skip_target : br_target; // see RULE_03
  assign multi = take && (cycles != CYC_ONE);
  assign fire = (take && !multi) || (state_q == ST_HOLD && left_q == CYC_ONE);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (multi) state_d = ST_HOLD; // see RULE_18
      ST_HOLD: if (left_q == CYC_ONE) state_d = ST_IDLE;
    endcase
  end

  // Sequencer state and remaining cycles
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      left_q <= 2'h0;
    end else begin
      state_q <= state_d;
      left_q <= take ? cycles - CYC_ONE : left_q - (left_q != 2'h0 ? CYC_ONE : 2'h0);
    end
  end

  // Capture results at acceptance
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      hold_q <= '0;
      hold_pc_load_q <= 1'b0;
      hold_pc_q <= '0;
    end else if (take) begin
      hold_q <= wb;
      hold_pc_load_q <= pc_load_now;
      hold_pc_q <= pc_now;
    end
  end

  // ==========================================================
  // Registered outputs, pulsed in the final cycle
  wb_s out_src;
  logic out_pc_load;
  logic [PC_W-1:0] out_pc;

  assign out_src = (state_q == ST_HOLD) ? hold_q : wb;
  assign out_pc_load = (state_q == ST_HOLD) ? hold_pc_load_q : pc_load_now;
  assign out_pc = (state_q == ST_HOLD) ? hold_pc_q : pc_now;

  // Busy while extra cycles run
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      busy_o <= (state_d == ST_HOLD);
      done_o <= fire;
    end
  end

  // Writeback strobes and data
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pc_load_o <= 1'b0;
      pc_o <= '0;
      rd_we_o <= 1'b0;
      rd_wdata_o <= DATA_RST;
      io_we_o <= 1'b0;
      io_wdata_o <= DATA_RST;
      flags_we_o <= 1'b0;
      flags_o <= DATA_RST;
    end else begin
      pc_load_o <= fire && out_pc_load;
      pc_o <= out_pc;
      rd_we_o <= fire && out_src.rd_we;
      rd_wdata_o <= out_src.rd_wdata;
      io_we_o <= fire && out_src.io_we;
      io_wdata_o <= out_src.io_wdata;
      flags_we_o <= fire && out_src.flags_we;
      flags_o <= out_src.flags;
    end
  end

endmodule

`default_nettype wire

//--- rtl/bit_branch_pkg.sv
/*
  Shared constants and types of the branch, skip, shift and flag
  instruction unit: flag positions, cycle counts, operation codes
  and the request carrier.
  Assumes the decode stage maps each instruction onto op_e.
*/
package bit_branch_pkg;

  // ==========================================================
  // Data widths
  localparam int DATA_W = 8;
  localparam int OFFS_W = 7;
  localparam int SEL_W = 3;

  // ==========================================================
  // Flag register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ==========================================================
  // Reset values and timing counts
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [1:0] SKIP_ONE_WORD = 2'h2;
  localparam logic [1:0] SKIP_TWO_WORD = 2'h3;

  // ==========================================================
  // Decoded operations
  typedef enum logic [5:0] {
    OP_NONE,
    OP_SKIP_IF_IO_BIT_ONE,
    OP_BRANCH_FLAG_BIT_ONE, OP_BRANCH_FLAG_BIT_ZERO,
    OP_BRANCH_ON_EQUAL, OP_BRANCH_ON_NOT_EQUAL,
    OP_BRANCH_CARRY_ONE, OP_BRANCH_CARRY_ZERO,
    OP_BRANCH_SAME_OR_HIGHER, OP_BRANCH_LOWER,
    OP_BRANCH_NEGATIVE, OP_BRANCH_POSITIVE,
    OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT,
    OP_BRANCH_HALFCARRY_ONE, OP_BRANCH_HALFCARRY_ZERO,
    OP_BRANCH_TRANSFER_ONE, OP_BRANCH_TRANSFER_ZERO,
    OP_BRANCH_OVERFLOW_ONE, OP_BRANCH_OVERFLOW_ZERO,
    OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED,
    OP_IO_BIT_FORCE_ONE, OP_IO_BIT_FORCE_ZERO,
    OP_LOGICAL_SHIFT_UP, OP_LOGICAL_SHIFT_DOWN,
    OP_ROTATE_UP_VIA_CARRY, OP_ROTATE_DOWN_VIA_CARRY,
    OP_ARITH_SHIFT_DOWN, OP_NIBBLE_EXCHANGE,
    OP_FLAG_BIT_FORCE_ONE, OP_FLAG_BIT_FORCE_ZERO,
    OP_CARRY_ONE, OP_CARRY_ZERO, OP_NEGATIVE_ONE, OP_NEGATIVE_ZERO,
    OP_ZERO_ONE, OP_ZERO_ZERO, OP_GLOBAL_IRQ_ENABLE, OP_GLOBAL_IRQ_DISABLE,
    OP_STORE_BIT_TO_TRANSFER, OP_LOAD_BIT_FROM_TRANSFER
  } op_e;

  // Sequencer states
  typedef enum logic {ST_IDLE, ST_HOLD} seq_e;

  // ==========================================================
  // Request from decode: op, bit or flag select, offset k
  typedef struct packed {
    op_e op;
    logic [SEL_W-1:0] bit_sel;
    logic [OFFS_W-1:0] offset;
    logic next_two_word;
  } instr_req_s;

  // Writeback set for register, I/O location and flags
  typedef struct packed {
    logic rd_we;
    logic [DATA_W-1:0] rd_wdata;
    logic io_we;
    logic [DATA_W-1:0] io_wdata;
    logic flags_we;
    logic [DATA_W-1:0] flags;
  } wb_s;

endpackage

//--- rtl/branch_cond.sv
/*
  Branch condition evaluator: picks the flag an operation tests and
  the polarity that makes the branch taken.
  Assumes flags_i is the live flag register of the core.
*/
`timescale 1ns/100ps
`default_nettype none

module branch_cond
  import bit_branch_pkg::*;
(
  // Operation
  input wire op_e op_i,
  input wire logic [SEL_W-1:0] bit_sel_i,
  // Flag register
  input wire logic [DATA_W-1:0] flags_i,
  // Result
  output logic is_branch_o,
  output logic taken_o
);

  // ==========================================================
  // Tested bit and polarity per operation
  logic tested;
  logic want_one;

  always_comb begin
    tested = 1'b0;
    want_one = 1'b1;
    is_branch_o = 1'b1;
    unique case (op_i)
      OP_BRANCH_FLAG_BIT_ONE: tested = flags_i[bit_sel_i]; // see RULE_02
      OP_BRANCH_FLAG_BIT_ZERO: begin
        tested = flags_i[bit_sel_i]; // see RULE_02
        want_one = 1'b0;
      end
      OP_BRANCH_ON_EQUAL: tested = flags_i[FLAG_Z]; // see RULE_03
      OP_BRANCH_ON_NOT_EQUAL: begin
        tested = flags_i[FLAG_Z]; // see RULE_03
        want_one = 1'b0;
      end
      OP_BRANCH_CARRY_ONE, OP_BRANCH_LOWER: tested = flags_i[FLAG_C]; // see RULE_04
      OP_BRANCH_CARRY_ZERO, OP_BRANCH_SAME_OR_HIGHER: begin
        tested = flags_i[FLAG_C]; // see RULE_04
        want_one = 1'b0;
      end
      OP_BRANCH_NEGATIVE: tested = flags_i[FLAG_N]; // see RULE_05
      OP_BRANCH_POSITIVE: begin
        tested = flags_i[FLAG_N]; // see RULE_05
        want_one = 1'b0;
      end
      OP_BRANCH_SIGNED_LT: tested = flags_i[FLAG_N] ^ flags_i[FLAG_V]; // see RULE_06
      OP_BRANCH_SIGNED_GE: begin
        tested = flags_i[FLAG_N] ^ flags_i[FLAG_V]; // see RULE_06
        want_one = 1'b0;
      end
      OP_BRANCH_HALFCARRY_ONE: tested = flags_i[FLAG_H]; // see RULE_07
      OP_BRANCH_HALFCARRY_ZERO: begin
        tested = flags_i[FLAG_H]; // see RULE_07
        want_one = 1'b0;
      end
      OP_BRANCH_TRANSFER_ONE: tested = flags_i[FLAG_T]; // see RULE_08
      OP_BRANCH_TRANSFER_ZERO: begin
        tested = flags_i[FLAG_T]; // see RULE_08
        want_one = 1'b0;
      end
      OP_BRANCH_OVERFLOW_ONE: tested = flags_i[FLAG_V]; // see RULE_09
      OP_BRANCH_OVERFLOW_ZERO: begin
        tested = flags_i[FLAG_V]; // see RULE_09
        want_one = 1'b0;
      end
      OP_BRANCH_IRQ_ENABLED: tested = flags_i[FLAG_I]; // see RULE_10
      OP_BRANCH_IRQ_DISABLED: begin
        tested = flags_i[FLAG_I]; // see RULE_10
        want_one = 1'b0;
      end
      default: is_branch_o = 1'b0;
    endcase
  end

  // Taken when the tested bit matches the wanted level
  assign taken_o = is_branch_o && (tested == want_one);

endmodule

`default_nettype wire

//--- testbench/bit_branch_unit_asserts.sv
/*
  Concurrent checks on the ports of the branch and bit unit.
  Assumes one clock domain, synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module bit_branch_unit_asserts
  import bit_branch_pkg::*;
#(
  parameter int PC_W = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Request and operands
  input wire logic req_valid_i,
  input wire instr_req_s req_i,
  input wire logic [DATA_W-1:0] rd_data_i,
  input wire logic [DATA_W-1:0] io_data_i,
  input wire logic [DATA_W-1:0] flags_i,
  input wire logic [PC_W-1:0] pc_i,
  // Unit outputs
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic pc_load_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic rd_we_o,
  input wire logic [DATA_W-1:0] rd_wdata_o,
  input wire logic io_we_o,
  input wire logic [DATA_W-1:0] io_wdata_o,
  input wire logic flags_we_o,
  input wire logic [DATA_W-1:0] flags_o
);
  // ==========================================================
  // Helper decode
  logic take;
  logic rd_bit;
  logic [PC_W-1:0] tgt;

  // Taking edge, selected bits and relative target
  assign take = req_valid_i && !busy_o;
  assign rd_bit = rd_data_i[req_i.bit_sel];
  assign tgt = pc_i + {{(PC_W-OFFS_W){req_i.offset[OFFS_W-1]}}, req_i.offset} + PC_W'(1);

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  // ==========================================================
  // Properties
  pc_with_done_a: assert property (pc_load_o |-> done_o)
    else $error("pc load without done");
  strobe_with_done_a: assert property ((rd_we_o || io_we_o || flags_we_o) |-> done_o)
    else $error("write strobe without done");
  busy_ends_done_a: assert property ($fell(busy_o) |-> done_o)
    else $error("busy fell without done");
  eq_taken_a: assert property (take && req_i.op == OP_BRANCH_ON_EQUAL && flags_i[FLAG_Z]
    |=> busy_o && !done_o ##1 done_o && pc_load_o && pc_o == $past(tgt, 2))
    else $error("equal branch target or timing wrong");
  ne_untaken_a: assert property (take && req_i.op == OP_BRANCH_ON_NOT_EQUAL && flags_i[FLAG_Z]
    |=> done_o && !pc_load_o && !busy_o)
    else $error("untaken branch not one cycle");
  ge_taken_a: assert property (take && req_i.op == OP_BRANCH_SIGNED_GE
    && flags_i[FLAG_N] == flags_i[FLAG_V] |-> ##2 pc_load_o && pc_o == $past(tgt, 2))
    else $error("signed ge branch not taken");
  skip_two_a: assert property (take && req_i.op == OP_SKIP_IF_IO_BIT_ONE
    && io_data_i[req_i.bit_sel] && req_i.next_two_word
    |=> busy_o [*2] ##1 done_o && pc_load_o && pc_o == $past(pc_i, 3) + SKIP_TWO_WORD)
    else $error("two word skip wrong");
  io_force_a: assert property (take && req_i.op == OP_IO_BIT_FORCE_ZERO |=> busy_o
    ##1 io_we_o && io_wdata_o == ($past(io_data_i, 2) & ~(8'h01 << $past(req_i.bit_sel, 2))))
    else $error("io bit force zero wrong");
  shift_up_a: assert property (take && req_i.op == OP_LOGICAL_SHIFT_UP |=> done_o && rd_we_o
    && rd_wdata_o == {$past(rd_data_i[6:0]), 1'b0} && flags_o[FLAG_C] == $past(rd_data_i[7]))
    else $error("logical shift up wrong");
  store_bit_a: assert property (take && req_i.op == OP_STORE_BIT_TO_TRANSFER
    |=> flags_we_o && flags_o[FLAG_T] == $past(rd_bit))
    else $error("bit store to transfer wrong");
endmodule

bind bit_branch_unit bit_branch_unit_asserts #(.PC_W(PC_W)) chk_u (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
  .rd_data_i(rd_data_i), .io_data_i(io_data_i), .flags_i(flags_i), .pc_i(pc_i),
  .busy_o(busy_o), .done_o(done_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
  .rd_we_o(rd_we_o), .rd_wdata_o(rd_wdata_o), .io_we_o(io_we_o), .io_wdata_o(io_wdata_o),
  .flags_we_o(flags_we_o), .flags_o(flags_o));

`default_nettype wire

//--- testbench/tb_bit_branch_unit.sv
/*
  Self-checking bench of the branch and bit unit.
  Assumes the package, unit and checker sources compile first.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_bit_branch_unit;
  import bit_branch_pkg::*;
  // ==========================================================
  // Signals and notes
  typedef struct packed {
    logic ld; logic [15:0] pc; logic [7:0] rd, io, fl; logic [1:0] n;
    logic [7:0] b_rd, b_io, b_fl; int t;
  } note_s;
  logic core_clk_i, nrst_i, req_valid_i, busy_o, done_o, pc_load_o;
  logic rd_we_o, io_we_o, flags_we_o;
  instr_req_s req_i;
  logic [7:0] rd_data_i, io_data_i, flags_i, rd_wdata_o, io_wdata_o, flags_o, lfsr;
  logic [15:0] pc_i, pc_o;
  note_s notes[$];
  note_s e;
  int err_total, checked;

  bit_branch_unit #(.PC_W(16)) dut_u (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .rd_data_i(rd_data_i), .io_data_i(io_data_i), .flags_i(flags_i), .pc_i(pc_i),
    .busy_o(busy_o), .done_o(done_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
    .rd_we_o(rd_we_o), .rd_wdata_o(rd_wdata_o), .io_we_o(io_we_o), .io_wdata_o(io_wdata_o),
    .flags_we_o(flags_we_o), .flags_o(flags_o));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  // Expected state after one request
  function automatic note_s model(op_e op, logic [2:0] s, logic [6:0] k, logic two,
      logic [7:0] rd, io, fl, logic [15:0] pc);
    note_s x;
    logic [9:0] v;
    int i;
    int pos[4] = '{FLAG_C, FLAG_N, FLAG_Z, FLAG_I};
    logic [7:0] r;
    logic c;
    logic sh;
    x = '0;
    // One cycle, no shift: n is 1, shift result and carry clear
    {x.rd, x.io, x.fl, x.b_rd, x.b_io, x.b_fl, x.n, sh, r, c} = {rd, io, fl, rd, io, fl, 12'h400};
    // One level per branch pair, the level that takes the first op of the pair
    v = {fl[FLAG_I], fl[FLAG_V], fl[FLAG_T], fl[FLAG_H],
         !(fl[FLAG_N] ^ fl[FLAG_V]), fl[FLAG_N], !fl[FLAG_C], fl[FLAG_C], fl[FLAG_Z], fl[s]};
    i = int'(op) - int'(OP_BRANCH_FLAG_BIT_ONE);
    if (i >= 0 && i < 20 && (v[i / 2] ^ i[0])) begin
      {x.ld, x.pc, x.n} = {1'b1, pc + {{9{k[6]}}, k} + 16'h1, 2'h2};
    end
    i = int'(op) - int'(OP_CARRY_ONE);
    if (i >= 0 && i < 8) x.fl[pos[i / 2]] = !i[0];
    case (op)
      OP_SKIP_IF_IO_BIT_ONE: if (io[s]) {x.ld, x.pc, x.n} = {1'b1, pc + (two ? 16'h3 : 16'h2),
        two ? 2'h3 : 2'h2};
      OP_IO_BIT_FORCE_ONE: {x.io[s], x.n} = {1'b1, 2'h2};
      OP_IO_BIT_FORCE_ZERO: {x.io[s], x.n} = {1'b0, 2'h2};
      OP_LOGICAL_SHIFT_UP: {c, r, sh} = {rd, 2'b01};
      OP_LOGICAL_SHIFT_DOWN: {r, c, sh} = {1'b0, rd, 1'b1};
      OP_ROTATE_UP_VIA_CARRY: {c, r, sh} = {rd, fl[FLAG_C], 1'b1};
      OP_ROTATE_DOWN_VIA_CARRY: {r, c, sh} = {fl[FLAG_C], rd, 1'b1};
      OP_ARITH_SHIFT_DOWN: {r, c, sh} = {rd[7], rd, 1'b1};
      OP_NIBBLE_EXCHANGE: x.rd = {rd[3:0], rd[7:4]};
      OP_FLAG_BIT_FORCE_ONE: x.fl[s] = 1'b1;
      OP_FLAG_BIT_FORCE_ZERO: x.fl[s] = 1'b0;
      OP_STORE_BIT_TO_TRANSFER: x.fl[FLAG_T] = rd[s];
      OP_LOAD_BIT_FROM_TRANSFER: x.rd[s] = fl[FLAG_T];
      default: ;
    endcase
    if (sh) begin
      {x.rd, x.fl[FLAG_Z], x.fl[FLAG_C], x.fl[FLAG_N], x.fl[FLAG_V]} = {r, r == 8'h00, c,
        r[7], r[7] ^ c};
    end
    return x;
  endfunction

  task automatic check(string nm, logic [42:0] x, logic [42:0] y);
    checked++;
    if (x !== y) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
    end
  endtask

  // Present one request, hold it while refused, note the expectation
  task automatic issue(op_e op, logic [2:0] s, logic [6:0] k, logic two, logic [7:0] rd, io, fl);
    note_s x;
    @(negedge core_clk_i);
    pc_i = {rnd(), rnd()};
    {req_valid_i, req_i.op, req_i.bit_sel, req_i.offset, req_i.next_two_word} = {1'b1, op, s, k,
      two};
    {rd_data_i, io_data_i, flags_i} = {rd, io, fl};
    for (int i = 0; i < 8 && busy_o !== 1'b0; i++) @(negedge core_clk_i);
    x = model(op, s, k, two, rd, io, fl, pc_i);
    @(posedge core_clk_i);
    x.t = $time;
    notes.push_back(x);
  endtask

  task automatic end_test(string nm);
    @(negedge core_clk_i);
    req_valid_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check("pending notes", 43'h0, 43'(notes.size()));
    notes.delete();
    $display("Test %s ended, %0d mismatches so far", nm, err_total);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and result monitor
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // Cut a hang short
  initial begin
    #(20000 * 50);
    err_total++;
    report_and_stop();
  end

  // Compare each completion with the oldest note
  always @(negedge core_clk_i) begin
    if (nrst_i === 1'b1 && done_o === 1'b1) begin
      if (notes.size() == 0) check("unexpected done", 43'h0, 43'h1);
      else begin
        e = notes.pop_front();
        check("result", {e.ld, e.pc, e.rd, e.io, e.fl, e.n}, {pc_load_o,
          pc_load_o ? pc_o : 16'h0, rd_we_o ? rd_wdata_o : e.b_rd, io_we_o ? io_wdata_o : e.b_io,
          flags_we_o ? flags_o : e.b_fl, 2'(($time - e.t + 25) / 50)});
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    {nrst_i, req_valid_i, req_i, rd_data_i, io_data_i, flags_i, pc_i} = '0;
    {err_total, checked, lfsr} = {32'h0, 32'h0, 8'h53};
    repeat (2) @(negedge core_clk_i);
    nrst_i = 1'b1;
    for (int i = OP_BRANCH_FLAG_BIT_ONE; i <= OP_BRANCH_IRQ_DISABLED; i++)
      for (int j = 0; j < 6; j++)
        issue(op_e'(i), 3'(rnd()), j == 0 ? 7'h40 : j == 1 ? 7'h3f : 7'(rnd()), 1'b0, rnd(),
          rnd(), j == 0 ? 8'h00 : j == 1 ? 8'hff : rnd());
    end_test("branches");
    for (int j = 0; j < 8; j++)
      issue(OP_SKIP_IF_IO_BIT_ONE, 3'(j), 7'h0, j[1], rnd(),
        j[0] ? (8'h01 << j) : ~(8'h01 << j), rnd());
    end_test("skips");
    for (int j = 0; j < 16; j++)
      issue(j < 8 ? OP_IO_BIT_FORCE_ONE : OP_IO_BIT_FORCE_ZERO, 3'(j), 7'h0, 1'b0, rnd(), rnd(),
        rnd());
    end_test("io bit force");
    for (int i = OP_LOGICAL_SHIFT_UP; i <= OP_LOAD_BIT_FROM_TRANSFER; i++)
      for (int j = 0; j < 4; j++)
        issue(op_e'(i), 3'(rnd()), 7'h0, 1'b0, j == 0 ? 8'h80 : j == 1 ? 8'h01 : rnd(), rnd(),
          rnd());
    end_test("shifts and flags");
    report_and_stop();
  end
endmodule

`default_nettype wire
